// File: hdl/led_ctrl_pkg.sv
// Shared constants and types for the LED driver serial port and pump mode control.
package led_ctrl_pkg;

   // Bus address of the device; the read/write bit must be zero.
   localparam logic [6:0] DEV_ADDR = 7'h1B;

   // Field positions of the camera level pair byte.
   localparam int CAM_HI_MSB = 7;
   localparam int CAM_HI_LSB = 4;
   localparam int CAM_LO_MSB = 3;
   localparam int CAM_LO_LSB = 0;

   // Field positions of the auxiliary and option byte.
   localparam int OPT_FORCE_DBL = 7;
   localparam int OPT_FORCE_3H = 6;
   localparam int OPT_TEST_TWO = 5;
   localparam int OPT_TEST_ONE = 4;
   localparam int OPT_CAM_SEL = 3;
   localparam int OPT_SHORT_DROP = 2;
   localparam int OPT_AUX_MSB = 1;
   localparam int OPT_AUX_LSB = 0;

   // Reset value of every register.
   localparam logic [7:0] REG_RESET = 8'h00;

   // Dropout persistence times and their cycle counts at the system clock.
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned DROP_LONG_MS = 150;
   localparam int unsigned DROP_SHORT_MS = 2;
   localparam int unsigned DROP_LONG_CYC = (CLK_HZ / 1000) * DROP_LONG_MS;
   localparam int unsigned DROP_SHORT_CYC = (CLK_HZ / 1000) * DROP_SHORT_MS;
   localparam int DROP_CNT_W = 22;

   // Charge pump modes as driven on the mode output.
   typedef enum logic [1:0] {MODE_1X, MODE_1P5, MODE_2X} pump_mode_e;

   // Serial link receive states.
   typedef enum logic [1:0] {LINK_IDLE, LINK_ADDR, LINK_DATA, LINK_SKIP} link_state_e;

endpackage : led_ctrl_pkg

// File: hdl/led_serial_mode_ctrl.sv
// Serial write port, current code registers and charge pump mode logic of the LED driver.
`timescale 1ns/1ps
module led_serial_mode_ctrl
   import led_ctrl_pkg::*;
   #(
   parameter int unsigned LONG_DELAY_CYC = DROP_LONG_CYC,
   parameter int unsigned SHORT_DELAY_CYC = DROP_SHORT_CYC
   )
   (
   // System clock and synchronous reset.
   input wire logic clk,
   input wire logic rst_n,
   // Two-wire serial link; scl also clocks the link-facing logic.
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Status pins from the analog side.
   input wire logic flash_select_pin,
   input wire logic dvcc_low,
   input wire logic over_temp,
   input wire logic dropout_main,
   input wire logic dropout_camera,
   // Main display current source control.
   output logic [7:0] main_code,
   output logic main_enable,
   // Camera current source control.
   output logic [3:0] camera_led_code,
   output logic camera_led_enable,
   // Auxiliary current source control.
   output logic [1:0] aux_code,
   output logic aux_enable,
   output logic aux_pull_low,
   // Charge pump control.
   output logic pump_output_enable,
   output logic [1:0] pump_mode
   );

   // ---------------------------------------------------------------------
   // Link domain, clocked by scl.
   // ---------------------------------------------------------------------

   logic lrst1_ff; // First stage of the link reset synchroniser.
   logic lrst2_ff; // Link reset, low while system reset or undervoltage.
   logic sda_rise_ff; // Data level captured on the rising clock edge.
   link_state_e link_state_ff; // Receive state.
   logic [3:0] bit_cnt_ff; // Bit in byte, 8 marks the acknowledge clock.
   logic [1:0] byte_cnt_ff; // Index of the data byte being received, 0 to 2.
   logic busy_ff; // Addressed and a full new set not yet received.
   logic [7:0] shift_ff; // Receive shift register.
   logic [7:0] stage_main_ff; // First data byte, waiting for the rest.
   logic [7:0] stage_cam_ff; // Second data byte, waiting for the rest.
   logic [7:0] hold_main_ff; // Last complete main brightness byte.
   logic [7:0] hold_cam_ff; // Last complete camera pair byte.
   logic [7:0] hold_opt_ff; // Last complete option byte.
   logic set_tgl_ff; // Flips each time a complete set is held.
   logic sda_oe_ff; // Acknowledge pull-down enable.
   logic sda_out_ff; // Driven level of the data pin, always low.

   // The link reset is synchronised into scl so that it releases cleanly.
   // It needs two rising scl edges; the bus idles high, so these must come as clock pulses before the first frame.
   always_ff @(posedge scl) begin
      lrst1_ff <= rst_n & ~dvcc_low;
      lrst2_ff <= lrst1_ff;
   end

   // Data is sampled on the rising clock edge, as the link demands.
   always_ff @(posedge scl) begin
      sda_rise_ff <= sda_in;
   end

   // Decode of the current link clock period, evaluated at the falling edge.
   logic start_cond; // Data fell while the clock was high.
   logic in_frame; // Receiving address or data bytes.
   logic byte_done; // Eighth bit of a byte is complete.
   logic [7:0] rx_byte; // Byte as it stands with the latest bit.
   logic addr_ok; // Received address is ours with a write bit.
   logic ack_now; // Acknowledge starts on this falling edge.
   logic ack_end; // Acknowledge clock ends on this falling edge.

   logic start_mark_ff; // Clock level at the last fall of data; high marks a start.
   logic start_mark_prev_ff; // Start mark as it stood at the previous falling clock edge.

   // A start is the only fall of data while the clock is high. Data's own edge
   // is used because a start right after a stop has no clock pulse between,
   // so clock-edge samples alone cannot tell it from a zero bit.
   always_ff @(negedge sda_in) begin
      start_mark_ff <= scl;
   end

   // The mark stays high while data stays low after a start, so only the
   // first falling clock edge after it counts as the start.
   always_ff @(negedge scl) begin
      if (!lrst2_ff) begin
         start_mark_prev_ff <= 1'b0;
      end else begin
         start_mark_prev_ff <= start_mark_ff;
      end
   end

   assign start_cond = start_mark_ff && !start_mark_prev_ff;
   assign in_frame = (link_state_ff == LINK_ADDR) || (link_state_ff == LINK_DATA);
   assign byte_done = in_frame && (bit_cnt_ff == 4'h7);
   assign ack_end = in_frame && (bit_cnt_ff == 4'h8);
   assign rx_byte = {shift_ff[6:0], sda_rise_ff};
   assign addr_ok = (rx_byte == {DEV_ADDR, 1'b0});
   assign ack_now = byte_done && ((link_state_ff == LINK_DATA) || addr_ok);

   // Receive sequencing: bit and byte counts, state and busy flag.
   always_ff @(negedge scl) begin
      if (!lrst2_ff) begin
         link_state_ff <= LINK_IDLE;
         bit_cnt_ff <= 4'h0;
         byte_cnt_ff <= 2'h0;
         busy_ff <= 1'b0;
      end else if (start_cond) begin
         // A start or repeated start always begins a new address byte.
         link_state_ff <= LINK_ADDR;
         bit_cnt_ff <= 4'h0;
         byte_cnt_ff <= 2'h0;
      end else if (in_frame) begin
         if (ack_end) begin
            bit_cnt_ff <= 4'h0;
            if (link_state_ff == LINK_ADDR) begin
               link_state_ff <= LINK_DATA;
            end else if (byte_cnt_ff == 2'h2) begin
               // Any byte past the third is neither stored nor acknowledged.
               link_state_ff <= LINK_SKIP;
            end else begin
               byte_cnt_ff <= byte_cnt_ff + 2'h1;
            end
         end else begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (byte_done && (link_state_ff == LINK_ADDR)) begin
               if (addr_ok) begin
                  // A stop is ignored from here until the new set is whole.
                  busy_ff <= 1'b1;
               end else begin
                  link_state_ff <= LINK_SKIP;
               end
            end
            if (ack_now && (link_state_ff == LINK_DATA) && (byte_cnt_ff == 2'h2)) begin
               busy_ff <= 1'b0;
            end
         end
      end
   end

   // Shift and byte capture. A byte is staged on its acknowledge and the set is
   // only held once all three bytes are in, so a broken frame never corrupts it.
   always_ff @(negedge scl) begin
      if (!lrst2_ff) begin
         shift_ff <= REG_RESET;
         stage_main_ff <= REG_RESET;
         stage_cam_ff <= REG_RESET;
         hold_main_ff <= REG_RESET;
         hold_cam_ff <= REG_RESET;
         hold_opt_ff <= REG_RESET;
         set_tgl_ff <= 1'b0;
      end else begin
         if (in_frame && !start_cond && (bit_cnt_ff < 4'h8)) begin
            shift_ff <= rx_byte;
         end
         if (ack_now && !start_cond && (link_state_ff == LINK_DATA)) begin
            unique case (byte_cnt_ff)
               2'h0: stage_main_ff <= rx_byte;
               2'h1: stage_cam_ff <= rx_byte;
               2'h2: begin
                  hold_main_ff <= stage_main_ff;
                  hold_cam_ff <= stage_cam_ff;
                  hold_opt_ff <= rx_byte;
                  set_tgl_ff <= ~set_tgl_ff;
               end
               default: ;
            endcase
         end
      end
   end

   // Acknowledge drive: pull data low for the ninth clock of each taken byte.
   always_ff @(negedge scl) begin
      sda_out_ff <= 1'b0;
      if (!lrst2_ff || start_cond) begin
         sda_oe_ff <= 1'b0;
      end else if (ack_now) begin
         sda_oe_ff <= 1'b1;
      end else if (ack_end) begin
         sda_oe_ff <= 1'b0;
      end
   end

   assign sda_oe = sda_oe_ff;
   assign sda_out = sda_out_ff;

   // ---------------------------------------------------------------------
   // System domain, clocked by clk.
   // ---------------------------------------------------------------------

   logic [8:0] sync1_ff; // First synchroniser stage, read only by the second.
   logic [8:0] sync2_ff; // Synchronised pins and link-domain levels.
   logic scl_s, sda_s, flash_s, uvlo_s, hot_s, drop_main_s, drop_cam_s, tgl_s, busy_s;

   // Every status pin, both bus pins and the link busy and toggle levels pass two flip-flops here.
   always_ff @(posedge clk) begin
      sync1_ff <= {busy_ff, set_tgl_ff, dropout_camera, dropout_main, over_temp,
                   dvcc_low, flash_select_pin, sda_in, scl};
      sync2_ff <= sync1_ff;
   end

   assign {busy_s, tgl_s, drop_cam_s, drop_main_s, hot_s, uvlo_s, flash_s, sda_s, scl_s} =
      sync2_ff;

   logic clr; // Registers are forced to zero.
   assign clr = !rst_n || uvlo_s;

   logic scl_prev_ff; // Clock level one cycle back.
   logic sda_prev_ff; // Data level one cycle back.
   logic flash_prev_ff; // Flash select level one cycle back.
   logic tgl_seen_ff; // Last set toggle taken over from the link.
   logic pending_ff; // A complete set waits for a stop.

   // Edge history of the synchronised pins.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
         flash_prev_ff <= 1'b0;
      end else begin
         scl_prev_ff <= scl_s;
         sda_prev_ff <= sda_s;
         flash_prev_ff <= flash_s;
      end
   end

   logic stop_cond; // Data rose while the clock stayed high.
   logic fresh_set; // Link reports a new complete set this cycle.
   logic load; // One-cycle load strobe into the current registers.
   logic flash_fall; // Flash select went from high to low.

   assign stop_cond = scl_s && scl_prev_ff && sda_s && !sda_prev_ff;
   assign fresh_set = (tgl_s != tgl_seen_ff);
   // The stop only takes effect when no new addressed frame is under way.
   assign load = stop_cond && (pending_ff || fresh_set) && !busy_s;
   assign flash_fall = flash_prev_ff && !flash_s;

   // Pending set tracking; a set arriving with the load is not lost.
   always_ff @(posedge clk) begin
      if (clr) begin
         tgl_seen_ff <= 1'b0;
         pending_ff <= 1'b0;
      end else begin
         tgl_seen_ff <= tgl_s;
         if (load) begin
            pending_ff <= 1'b0;
         end else if (fresh_set) begin
            pending_ff <= 1'b1;
         end
      end
   end

   logic [7:0] main_brightness_code_ff; // Main display code in use.
   logic [7:0] camera_level_pair_ff; // Camera high and low codes in use.
   logic [7:0] aux_and_option_byte_ff; // Auxiliary code and option bits in use.

   // Current registers; the held link data is stable while the strobe is
   // seen, because it changes only one full frame after the toggle.
   always_ff @(posedge clk) begin
      if (clr) begin
         main_brightness_code_ff <= REG_RESET;
         camera_level_pair_ff <= REG_RESET;
         aux_and_option_byte_ff <= REG_RESET;
      end else if (load) begin
         main_brightness_code_ff <= hold_main_ff;
         camera_level_pair_ff <= hold_cam_ff;
         aux_and_option_byte_ff <= hold_opt_ff;
      end
   end

   // Option decode. Test bits are stored but steer nothing.
   logic force_dbl, force_3h, force_any, cam_sel_bit, short_bit;
   logic cam_high; // Camera high code selected.
   logic [3:0] cam_code; // Selected camera code.
   logic [1:0] aux_lvl; // Auxiliary level code.
   logic main_on, cam_on, aux_on; // Group codes are nonzero.

   assign force_dbl = aux_and_option_byte_ff[OPT_FORCE_DBL];
   assign force_3h = aux_and_option_byte_ff[OPT_FORCE_3H];
   assign force_any = force_dbl || force_3h;
   assign cam_sel_bit = aux_and_option_byte_ff[OPT_CAM_SEL];
   assign short_bit = aux_and_option_byte_ff[OPT_SHORT_DROP];
   assign aux_lvl = aux_and_option_byte_ff[OPT_AUX_MSB:OPT_AUX_LSB];
   // The select bit forces the high code; when clear the pin chooses.
   assign cam_high = cam_sel_bit || flash_s;
   assign cam_code = cam_high ? camera_level_pair_ff[CAM_HI_MSB:CAM_HI_LSB] :
                                camera_level_pair_ff[CAM_LO_MSB:CAM_LO_LSB];
   assign main_on = (main_brightness_code_ff != REG_RESET);
   assign cam_on = (cam_code != 4'h0);
   assign aux_on = (aux_lvl != 2'h0);

   // Dropout is only counted at enabled main and camera groups; the auxiliary
   // output has no sensing and is left out on purpose.
   logic dropout_q;
   assign dropout_q = (drop_main_s && main_on) || (drop_cam_s && cam_on);

   // Persistence limit: short when the option bit is set or when the pin is
   // in control and high, so a flash can boost quickly.
   logic [DROP_CNT_W-1:0] drop_limit;
   assign drop_limit = (short_bit || (flash_s && !cam_sel_bit)) ?
                       DROP_CNT_W'(SHORT_DELAY_CYC) : DROP_CNT_W'(LONG_DELAY_CYC);

   pump_mode_e auto_mode_ff; // Mode chosen by the dropout logic.
   logic [DROP_CNT_W-1:0] drop_cnt_ff; // Cycles of unbroken dropout.

   // Automatic mode stepping. Any break in dropout restarts the count, so a
   // step needs the whole delay of continuous dropout.
   always_ff @(posedge clk) begin
      if (clr) begin
         auto_mode_ff <= MODE_1X;
         drop_cnt_ff <= '0;
      end else if (load || flash_fall) begin
         auto_mode_ff <= MODE_1X;
         drop_cnt_ff <= '0;
      end else if (force_any || hot_s || !dropout_q || (auto_mode_ff == MODE_2X)) begin
         drop_cnt_ff <= '0;
      end else if (drop_cnt_ff >= drop_limit - DROP_CNT_W'(1)) begin
         drop_cnt_ff <= '0;
         unique case (auto_mode_ff)
            MODE_1X: auto_mode_ff <= MODE_1P5;
            MODE_1P5: auto_mode_ff <= MODE_2X;
            default: auto_mode_ff <= MODE_2X;
         endcase
      end else begin
         drop_cnt_ff <= drop_cnt_ff + DROP_CNT_W'(1);
      end
   end

   logic [7:0] main_code_ff;
   logic main_enable_ff;
   logic [3:0] camera_led_code_ff;
   logic camera_led_enable_ff;
   logic [1:0] aux_code_ff;
   logic aux_enable_ff;
   logic aux_pull_low_ff;
   logic pump_output_enable_ff;
   logic [1:0] pump_mode_ff;

   // Output stage. Over-temperature blanks every source and the pump and they
   // come back on their own when it clears; the codes are kept meanwhile.
   always_ff @(posedge clk) begin
      if (clr) begin
         main_code_ff <= REG_RESET;
         main_enable_ff <= 1'b0;
         camera_led_code_ff <= 4'h0;
         camera_led_enable_ff <= 1'b0;
         aux_code_ff <= 2'h0;
         aux_enable_ff <= 1'b0;
         aux_pull_low_ff <= 1'b0;
         pump_output_enable_ff <= 1'b0;
         pump_mode_ff <= MODE_1X;
      end else begin
         main_code_ff <= hot_s ? REG_RESET : main_brightness_code_ff;
         main_enable_ff <= main_on && !hot_s;
         camera_led_code_ff <= hot_s ? 4'h0 : cam_code;
         camera_led_enable_ff <= cam_on && !hot_s;
         aux_code_ff <= hot_s ? 2'h0 : aux_lvl;
         aux_enable_ff <= aux_on && !hot_s;
         // Used as a plain output the auxiliary pin sinks whenever its code
         // is nonzero, so the serial port sets it low or released.
         aux_pull_low_ff <= aux_on && !hot_s;
         // The pump idles when every group is off, unless it is forced to
         // serve as a fixed supply.
         pump_output_enable_ff <= !hot_s && (main_on || cam_on || aux_on || force_any);
         if (force_dbl) begin
            pump_mode_ff <= MODE_2X;
         end else if (force_3h) begin
            pump_mode_ff <= MODE_1P5;
         end else begin
            pump_mode_ff <= auto_mode_ff;
         end
      end
   end

   assign main_code = main_code_ff;
   assign main_enable = main_enable_ff;
   assign camera_led_code = camera_led_code_ff;
   assign camera_led_enable = camera_led_enable_ff;
   assign aux_code = aux_code_ff;
   assign aux_enable = aux_enable_ff;
   assign aux_pull_low = aux_pull_low_ff;
   assign pump_output_enable = pump_output_enable_ff;
   assign pump_mode = pump_mode_ff;

endmodule : led_serial_mode_ctrl

// File: bench/led_ctrl_props.sv
// Concurrent checks on the ports of the LED driver control block.
`timescale 1ns/1ps
module led_ctrl_props
   import led_ctrl_pkg::*;
   (
   // Clocks and reset.
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl,
   // Link pin drive and status inputs.
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic dvcc_low,
   input wire logic over_temp,
   // Current source and pump outputs.
   input wire logic [7:0] main_code,
   input wire logic main_enable,
   input wire logic [3:0] camera_led_code,
   input wire logic camera_led_enable,
   input wire logic [1:0] aux_code,
   input wire logic aux_enable,
   input wire logic aux_pull_low,
   input wire logic pump_output_enable,
   input wire logic [1:0] pump_mode
   );
   // Synchroniser plus output flop is three edges, so five leaves margin.
   sequence hot_held; over_temp [*5]; endsequence
   sequence low_supply; dvcc_low [*5]; endsequence
   main_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      main_enable == (main_code != 8'h00)) else $error("Main enable mismatch.");
   cam_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      camera_led_enable == (camera_led_code != 4'h0)) else $error("Camera enable mismatch.");
   aux_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      aux_enable == (aux_code != 2'h0)) else $error("Aux enable mismatch.");
   aux_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
      aux_pull_low == aux_enable) else $error("Aux pin mismatch.");
   mode_legal_a: assert property (@(posedge clk) disable iff (!rst_n)
      pump_mode != 2'h3) else $error("Illegal pump mode.");
   hot_off_a: assert property (@(posedge clk) disable iff (!rst_n) hot_held |->
      !main_enable && !camera_led_enable && !aux_enable && !pump_output_enable)
      else $error("Sources on while hot.");
   uv_clear_a: assert property (@(posedge clk) disable iff (!rst_n) low_supply |->
      main_code == 8'h00 && !aux_enable && pump_mode == MODE_1X)
      else $error("Registers not cleared.");
   ack_len_a: assert property (@(negedge scl) disable iff (!rst_n)
      $rose(sda_oe) |=> !sda_oe) else $error("Ack longer than one clock.");
   ack_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      sda_oe |-> !sda_out) else $error("Ack not driven low.");
endmodule : led_ctrl_props

bind led_serial_mode_ctrl led_ctrl_props u_props (.clk, .rst_n, .scl, .sda_out,
   .sda_oe, .dvcc_low, .over_temp, .main_code, .main_enable, .camera_led_code,
   .camera_led_enable, .aux_code, .aux_enable, .aux_pull_low, .pump_output_enable,
   .pump_mode);

// File: bench/i2c_host_model.sv
// Two-wire bus master model that writes frames to the LED driver.
`timescale 1ns/1ps
module i2c_host_model (
   // Bus wires towards the device.
   output logic scl,
   output logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe
   );
   logic sda_m; // Master drive level; one means released.
   // The pull-up keeps the wire high unless a party sinks it.
   assign sda_in = sda_m & ~(sda_oe & ~sda_out);
   // The bus idles with both lines high; the clock stands still between frames.
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // One bit: data changes while the clock is low, sampled on the rise.
   task automatic put_bit(input logic b, output logic seen);
      sda_m = b;
      #16 scl = 1'b1;
      #16 seen = sda_in;
      #16 scl = 1'b0;
      #16;
   endtask : put_bit
   // A byte goes out MSB first; the wire is released for the ninth clock.
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(d[i], s);
      put_bit(1'b1, s);
      ack = ~s;
   endtask : put_byte
   // Start, address, n data bytes taken from the top of dat, then stop.
   task automatic frame(input logic [7:0] adr, input logic [31:0] dat,
                        input int n, output logic [4:0] acks);
      logic a;
      acks = 5'h00;
      sda_m = 1'b0;
      #16 scl = 1'b0;
      #16;
      put_byte(adr, a);
      acks[0] = a;
      for (int k = 0; k < n; k++) begin
         put_byte(dat[31-8*k -: 8], a);
         acks[k+1] = a;
      end
      sda_m = 1'b0;
      #16 scl = 1'b1;
      // Stop setup and bus-free time span several system clocks, so the
      // sampled pins show the clock high before data rises.
      #112 sda_m = 1'b1;
      #128;
   endtask : frame
   // Two clock pulses with data high let the link side leave reset.
   task automatic idle_pulses();
      repeat (2) begin
         #16 scl = 1'b0;
         #32 scl = 1'b1;
         #16;
      end
   endtask : idle_pulses
endmodule : i2c_host_model

// File: bench/tb.sv
// Self-checking testbench for the LED driver serial port and pump mode control.
`timescale 1ns/1ps
module tb;
   import led_ctrl_pkg::*;
   localparam int LD = 60; // Shortened long dropout delay, in clocks.
   localparam int SD = 10; // Shortened short dropout delay, in clocks.
   logic clk, rst_n, flash, dvcc_low, over_temp, drop_m, drop_c;
   logic scl, sda_in, sda_out, sda_oe, main_en, cam_en, aux_en, aux_pl, pump_en;
   logic [7:0] main_code, ra, rb, rc;
   logic [3:0] cam_code;
   logic [1:0] aux_code, pump_mode;
   logic [4:0] acks;
   int err_count, n_checks, seed;
   led_serial_mode_ctrl #(.LONG_DELAY_CYC(LD), .SHORT_DELAY_CYC(SD)) u_dut (
      .clk, .rst_n, .scl, .sda_in, .sda_out, .sda_oe, .flash_select_pin(flash),
      .dvcc_low, .over_temp, .dropout_main(drop_m), .dropout_camera(drop_c),
      .main_code, .main_enable(main_en), .camera_led_code(cam_code),
      .camera_led_enable(cam_en), .aux_code, .aux_enable(aux_en),
      .aux_pull_low(aux_pl), .pump_output_enable(pump_en), .pump_mode);
   i2c_host_model u_host (.scl, .sda_in, .sda_out, .sda_oe);
   // The 50 ns system clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Prints the counts and the verdict, then stops the run.
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude
   // Four-state compare; an unknown never passes.
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // The select bit overrides the pin; otherwise the pin picks the code.
   function automatic logic [3:0] exp_cam(input logic [7:0] b, c, input logic f);
      return (c[3] | f) ? b[7:4] : b[3:0];
   endfunction : exp_cam
   // Force double wins over force three-halves; a load restarts auto at 1x.
   function automatic logic [1:0] exp_mode(input logic [7:0] c);
      return c[7] ? MODE_2X : (c[6] ? MODE_1P5 : MODE_1X);
   endfunction : exp_mode
   // Writes a full set, waits out the load and compares the acks, the three codes and the pump mode.
   task automatic load(input logic [7:0] a, b, c);
      u_host.frame({DEV_ADDR, 1'b0}, {a, b, c, 8'h00}, 3, acks);
      check("acks", 8'h0F, {3'b000, acks});
      repeat (12) @(posedge clk);
      check("main", a, main_code);
      check("cam", exp_cam(b, c, flash), cam_code);
      check("aux", {6'h00, c[1:0]}, {6'h00, aux_code});
      check("mode", exp_mode(c), pump_mode);
      $display("load %h %h %h done", a, b, c);
   endtask : load
   // Counts clocks until the pump reaches mode m; early or late is wrong.
   task automatic wait_mode(input logic [1:0] m, input int lo, input int hi);
      int n;
      n = 0;
      while (pump_mode !== m && n < hi) begin
         @(posedge clk);
         n++;
      end
      check("step_time", 8'h01, {7'h00, n >= lo && n < hi});
      if (n >= hi) conclude();
   endtask : wait_mode
   // Watchdog so that no hang outlives the run.
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      conclude();
   end
   initial begin
      seed = 32'hb6d1;
      err_count = 0;
      n_checks = 0;
      {rst_n, flash, dvcc_low, over_temp, drop_m, drop_c} = 6'h00;
      u_host.idle_pulses();
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      // The link side leaves reset only on clock pulses given after release.
      u_host.idle_pulses();
      repeat (6) @(posedge clk);
      check("mode_rst", MODE_1X, pump_mode);
      // Random sets; the test bits are always written as zero.
      repeat (8) begin
         ra = 8'($random(seed));
         rb = 8'($random(seed));
         rc = 8'($random(seed)) & 8'hCF;
         @(posedge clk) flash <= 1'($random(seed));
         load(ra, rb, rc);
      end
      // The pin picks the camera code with no serial access.
      @(posedge clk) flash <= 1'b0;
      load(8'h80, 8'hA5, 8'h00);
      @(posedge clk) flash <= 1'b1;
      repeat (5) @(posedge clk);
      check("cam_hi", 8'h0A, cam_code);
      // Refused frames: read bit set, foreign address, a fourth byte.
      u_host.frame(8'h37, 32'h1122_3300, 3, acks);
      check("rd_ack", 8'h00, acks);
      u_host.frame(8'h38, 32'h1122_3300, 3, acks);
      check("adr_ack", 8'h00, acks);
      repeat (12) @(posedge clk);
      check("kept", 8'h80, main_code);
      u_host.frame(8'h36, 32'h0011_0444, 4, acks);
      check("ack4", 8'h0F, acks);
      repeat (12) @(posedge clk);
      check("zero_en", 8'h00, {main_en, aux_en});
      // Automatic steps after the long delay, then the pin's falling edge.
      @(posedge clk) flash <= 1'b0;
      load(8'h40, 8'h33, 8'h00);
      drop_m <= 1'b1;
      wait_mode(MODE_1P5, LD - 3, LD + 12);
      wait_mode(MODE_2X, LD - 3, LD + 12);
      flash <= 1'b1;
      repeat (4) @(posedge clk);
      flash <= 1'b0;
      wait_mode(MODE_1X, 0, 8);
      drop_m <= 1'b0;
      load(8'h40, 8'h33, 8'h04);
      drop_m <= 1'b1;
      wait_mode(MODE_1P5, SD - 3, SD + 12);
      drop_m <= 1'b0;
      flash <= 1'b1;
      load(8'h40, 8'h33, 8'h00);
      drop_c <= 1'b1;
      wait_mode(MODE_1P5, SD - 3, SD + 12);
      flash <= 1'b0;
      load(8'h40, 8'h33, 8'h40);
      repeat (LD + 20) @(posedge clk);
      check("forced", MODE_1P5, pump_mode);
      drop_c <= 1'b0;
      // Thermal shutdown and recovery.
      over_temp <= 1'b1;
      repeat (6) @(posedge clk);
      check("hot", 8'h00, {main_code[6:0], pump_en});
      over_temp <= 1'b0;
      repeat (6) @(posedge clk);
      check("cool", 8'h40, main_code);
      // Undervoltage clears every register; then a full-scale set.
      dvcc_low <= 1'b1;
      u_host.idle_pulses();
      repeat (6) @(posedge clk);
      dvcc_low <= 1'b0;
      u_host.idle_pulses();
      repeat (6) @(posedge clk);
      check("uv", 8'h00, {main_code[6:0], aux_en});
      load(8'hFF, 8'hFF, 8'h03);
      conclude();
   end
endmodule : tb
